// ---- hw/fts_pkg.sv ----
// fts_pkg: shared constants and types for the fault and throttle status bank
package fts_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] FAULT_ADDR = 8'h4B;
  localparam logic [7:0] THROT_ADDR = 8'h4C;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ----------------------------------------
  // fault register bit positions
  // ----------------------------------------
  localparam int FB_PAIR_1B = 0;
  localparam int FB_PAIR_2B = 1;
  localparam int FB_FUSE_A = 2;
  localparam int FB_FUSE_B = 3;
  localparam int FB_VCORE1 = 4;
  localparam int FB_VCORE2 = 5;
  localparam int FB_PAIR_1A = 6;
  localparam int FB_PAIR_2A = 7;
  // ----------------------------------------
  // throttle register bit positions
  // ----------------------------------------
  localparam int TB_ANY = 0;
  localparam int TB_LOW = 1;
  localparam int TB_SECOND = 2;
  localparam int TB_THIRD = 3;
  localparam int TB_FOURTH = 4;
  localparam int TB_HIGH = 5;
  localparam int TB_FULL = 6;
  localparam int TB_LIMIT = 7;
  // ----------------------------------------
  // throttle duty thresholds, in 1/256 of full scale
  // ----------------------------------------
  localparam logic [8:0] DUTY_12P5 = 9'h020;
  localparam logic [8:0] DUTY_25 = 9'h040;
  localparam logic [8:0] DUTY_50 = 9'h080;
  localparam logic [8:0] DUTY_75 = 9'h0C0;
  localparam logic [8:0] DUTY_FULL = 9'h100;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic pair_2a;
    logic pair_1a;
    logic pair_2b;
    logic pair_1b;
  } fts_diode_t;
  typedef struct packed {
    logic valid;
    logic [8:0] duty;
  } fts_duty_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fts_req_t;
endpackage

// ---- hw/fts_status_bank.sv ----
// fts_status_bank: fault and cpu1 throttle sticky status registers
// What this block does
// R1: set bit 0 on open or short fault of remote diode pair 1b.
// R2: set bit 1 on open or short fault of remote diode pair 2b.
// R3: set bit 6 on open or short fault of remote diode pair 1a.
// R4: set bit 7 on open or short fault of remote diode pair 2a.
// R5: set bits 2 and 3 on fuse sense inputs, only in regulator-10 mode.
// R6: set bit 4 when cpu1 core voltage mismatches its requested code.
// R7: set bit 5 when cpu2 core voltage mismatches the requested voltage.
// R8: set throttle bit 1 for duty from 0 up to below 12.5 percent.
// R9: set throttle bit 2 for duty from 12.5 up to below 25 percent.
// R10: set throttle bit 3 for duty from 25 up to below 50 percent.
// R11: set throttle bit 4 for duty from 50 up to below 75 percent.
// R12: set throttle bit 7 when duty exceeds the programmed limit.
// R13: only the over-limit flag feeds the host error summary.
// R14: set throttle bit 0 for any throttling above zero percent.
// R15: bit 5 for 75 to below 100 percent, bit 6 at full 100.
// R16: flags stay set until host write clears them; reset to zero.
`timescale 1ns/1ps
module fts_status_bank (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // host register access
  input wire fts_pkg::fts_req_t host_req,
  output logic [7:0] host_rdata_q,
  // fault detectors
  input wire fts_pkg::fts_diode_t diode_fault,
  input wire logic fuse_sense_a,
  input wire logic fuse_sense_b,
  input wire logic vid_mode_regulator10,
  input wire logic cpu1_vcore_mismatch,
  input wire logic cpu2_vcore_mismatch,
  // throttle measurement
  input wire fts_pkg::fts_duty_t cpu1_duty,
  input wire logic [8:0] throttle_limit,
  // status outputs
  output logic [7:0] fault_status_q,
  output logic [7:0] throttle_status_q,
  output logic host_err_q
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    return a == reg_addr;
  endfunction

  logic fault_clr;
  logic throt_clr;
  always_comb begin
    fault_clr = 1'b0;
    throt_clr = 1'b0;
    if (host_req.wr && hit(host_req.addr, fts_pkg::FAULT_ADDR)) begin
      fault_clr = 1'b1;
    end else if (host_req.wr && hit(host_req.addr, fts_pkg::THROT_ADDR)) begin
      throt_clr = 1'b1;
    end
  end

  // ----------------------------------------
  // fault event vector
  // ----------------------------------------
  logic [7:0] fault_set;
  always_comb begin
    fault_set = 8'h00;
    fault_set[fts_pkg::FB_PAIR_1B] = diode_fault.pair_1b; // R1
    fault_set[fts_pkg::FB_PAIR_2B] = diode_fault.pair_2b; // R2
    fault_set[fts_pkg::FB_PAIR_1A] = diode_fault.pair_1a; // R3
    fault_set[fts_pkg::FB_PAIR_2A] = diode_fault.pair_2a; // R4
    fault_set[fts_pkg::FB_FUSE_A] = fuse_sense_a && vid_mode_regulator10; // R5
    fault_set[fts_pkg::FB_FUSE_B] = fuse_sense_b && vid_mode_regulator10; // R5
    fault_set[fts_pkg::FB_VCORE1] = cpu1_vcore_mismatch; // R6
    fault_set[fts_pkg::FB_VCORE2] = cpu2_vcore_mismatch; // R7
  end

  // ----------------------------------------
  // throttle band classification
  // ----------------------------------------
  logic [7:0] throt_set;
  logic [8:0] d;
  always_comb begin
    d = cpu1_duty.duty;
    throt_set = 8'h00;
    if (cpu1_duty.valid) begin
      throt_set[fts_pkg::TB_ANY] = d != 9'h000; // R14
      throt_set[fts_pkg::TB_LOW] = d < fts_pkg::DUTY_12P5; // R8
      throt_set[fts_pkg::TB_SECOND] = d >= fts_pkg::DUTY_12P5 && d < fts_pkg::DUTY_25; // R9
      throt_set[fts_pkg::TB_THIRD] = d >= fts_pkg::DUTY_25 && d < fts_pkg::DUTY_50; // R10
      throt_set[fts_pkg::TB_FOURTH] = d >= fts_pkg::DUTY_50 && d < fts_pkg::DUTY_75; // R11
      throt_set[fts_pkg::TB_HIGH] = d >= fts_pkg::DUTY_75 && d < fts_pkg::DUTY_FULL; // R15
      throt_set[fts_pkg::TB_FULL] = d >= fts_pkg::DUTY_FULL; // R15
      throt_set[fts_pkg::TB_LIMIT] = d > throttle_limit; // R12
    end
  end

  // ----------------------------------------
  // sticky registers
  // ----------------------------------------
  fts_sticky_reg #(.WIDTH(8)) u_fault (
    .core_clk(core_clk),
    .rstn(rstn),
    .set_in(fault_set),
    .clr_en(fault_clr),
    .clr_mask(host_req.wdata),
    .flags_q(fault_status_q)
  );

  fts_sticky_reg #(.WIDTH(8)) u_throt (
    .core_clk(core_clk),
    .rstn(rstn),
    .set_in(throt_set),
    .clr_en(throt_clr),
    .clr_mask(host_req.wdata),
    .flags_q(throttle_status_q)
  );

  // ----------------------------------------
  // host error summary
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      host_err_q <= 1'b0;
    end else begin
      host_err_q <= throttle_status_q[fts_pkg::TB_LIMIT]; // R13
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      host_rdata_q <= fts_pkg::REG_RESET;
    end else if (host_req.rd && hit(host_req.addr, fts_pkg::FAULT_ADDR)) begin
      host_rdata_q <= fault_status_q;
    end else if (host_req.rd && hit(host_req.addr, fts_pkg::THROT_ADDR)) begin
      host_rdata_q <= throttle_status_q;
    end else if (host_req.rd) begin
      host_rdata_q <= 8'h00;
    end
  end

  // ----------------------------------------
  // fault checks
  // ----------------------------------------
  a_pair_1b_set: assert property (@(posedge core_clk) disable iff (!rstn) // R1
    diode_fault.pair_1b |=> fault_status_q[fts_pkg::FB_PAIR_1B]) else $error("pair 1b flag");
  a_pair_2b_set: assert property (@(posedge core_clk) disable iff (!rstn) // R2
    diode_fault.pair_2b |=> fault_status_q[fts_pkg::FB_PAIR_2B]) else $error("pair 2b flag");
  a_pair_1a_set: assert property (@(posedge core_clk) disable iff (!rstn) // R3
    diode_fault.pair_1a |=> fault_status_q[fts_pkg::FB_PAIR_1A]) else $error("pair 1a flag");
  a_pair_2a_set: assert property (@(posedge core_clk) disable iff (!rstn) // R4
    diode_fault.pair_2a |=> fault_status_q[fts_pkg::FB_PAIR_2A]) else $error("pair 2a flag");
  a_fuse_gated: assert property (@(posedge core_clk) disable iff (!rstn) // R5
    !vid_mode_regulator10 && !fault_status_q[fts_pkg::FB_FUSE_A]
    |=> !fault_status_q[fts_pkg::FB_FUSE_A]) else $error("fuse flag set outside mode");
  a_fuse_a_set: assert property (@(posedge core_clk) disable iff (!rstn) // R5
    vid_mode_regulator10 && fuse_sense_a |=> fault_status_q[fts_pkg::FB_FUSE_A])
    else $error("fuse a flag");
  a_fuse_b_set: assert property (@(posedge core_clk) disable iff (!rstn) // R5
    vid_mode_regulator10 && fuse_sense_b |=> fault_status_q[fts_pkg::FB_FUSE_B])
    else $error("fuse b flag");
  a_vcore1_set: assert property (@(posedge core_clk) disable iff (!rstn) // R6
    cpu1_vcore_mismatch |=> fault_status_q[fts_pkg::FB_VCORE1]) else $error("vcore1 flag");
  a_vcore2_set: assert property (@(posedge core_clk) disable iff (!rstn) // R7
    cpu2_vcore_mismatch |=> fault_status_q[fts_pkg::FB_VCORE2]) else $error("vcore2 flag");
  // ----------------------------------------
  // throttle checks
  // ----------------------------------------
  a_band_low: assert property (@(posedge core_clk) disable iff (!rstn) // R8
    cpu1_duty.valid && cpu1_duty.duty < fts_pkg::DUTY_12P5
    |=> throttle_status_q[fts_pkg::TB_LOW]) else $error("low band flag");
  a_band_third: assert property (@(posedge core_clk) disable iff (!rstn) // R10
    cpu1_duty.valid && cpu1_duty.duty == fts_pkg::DUTY_25
    |=> throttle_status_q[fts_pkg::TB_THIRD]) else $error("third band flag");
  a_band_second: assert property (@(posedge core_clk) disable iff (!rstn) // R9
    cpu1_duty.valid && cpu1_duty.duty >= fts_pkg::DUTY_12P5
    && cpu1_duty.duty < fts_pkg::DUTY_25 |=> throttle_status_q[fts_pkg::TB_SECOND])
    else $error("second band flag");
  a_band_fourth: assert property (@(posedge core_clk) disable iff (!rstn) // R11
    cpu1_duty.valid && cpu1_duty.duty >= fts_pkg::DUTY_50
    && cpu1_duty.duty < fts_pkg::DUTY_75 |=> throttle_status_q[fts_pkg::TB_FOURTH])
    else $error("fourth band flag");
  a_band_high: assert property (@(posedge core_clk) disable iff (!rstn) // R15
    cpu1_duty.valid && cpu1_duty.duty >= fts_pkg::DUTY_75
    && cpu1_duty.duty < fts_pkg::DUTY_FULL |=> throttle_status_q[fts_pkg::TB_HIGH])
    else $error("high band flag");
  a_band_full: assert property (@(posedge core_clk) disable iff (!rstn) // R15
    cpu1_duty.valid && cpu1_duty.duty >= fts_pkg::DUTY_FULL
    |=> throttle_status_q[fts_pkg::TB_FULL]) else $error("full throttle flag");
  a_any_set: assert property (@(posedge core_clk) disable iff (!rstn) // R14
    cpu1_duty.valid && cpu1_duty.duty != 9'h000
    |=> throttle_status_q[fts_pkg::TB_ANY]) else $error("any throttle flag");
  a_limit_set: assert property (@(posedge core_clk) disable iff (!rstn) // R12
    cpu1_duty.valid && cpu1_duty.duty > throttle_limit
    |=> throttle_status_q[fts_pkg::TB_LIMIT]) else $error("limit flag");
  a_limit_summary: assert property (@(posedge core_clk) disable iff (!rstn) // R13
    cpu1_duty.valid && cpu1_duty.duty > throttle_limit |=> ##1 host_err_q)
    else $error("summary not raised");
  a_summary_only: assert property (@(posedge core_clk) disable iff (!rstn) // R13
    host_err_q == $past(throttle_status_q[fts_pkg::TB_LIMIT]))
    else $error("summary differs from limit flag");
  // ----------------------------------------
  // host access checks
  // ----------------------------------------
  a_sticky_hold: assert property (@(posedge core_clk) disable iff (!rstn) // R16
    fault_status_q[fts_pkg::FB_PAIR_1B] && !fault_clr |=> fault_status_q[fts_pkg::FB_PAIR_1B])
    else $error("flag lost without clear");
  a_clear_pair: assert property (@(posedge core_clk) disable iff (!rstn) // R16
    fault_clr && host_req.wdata[fts_pkg::FB_PAIR_1B] && !diode_fault.pair_1b
    |=> !fault_status_q[fts_pkg::FB_PAIR_1B]) else $error("flag not cleared");
  a_read_fault: assert property (@(posedge core_clk) disable iff (!rstn) // R16
    host_req.rd && host_req.addr == fts_pkg::FAULT_ADDR
    |=> host_rdata_q == $past(fault_status_q)) else $error("fault read data");
  // ----------------------------------------
  // coverage
  // ----------------------------------------
  c_fault_clear: cover property (@(posedge core_clk) disable iff (!rstn)
    fault_status_q != 8'h00 && fault_clr ##1 fault_status_q == 8'h00);
  c_full_throttle: cover property (@(posedge core_clk) disable iff (!rstn)
    throttle_status_q[fts_pkg::TB_FULL]);
  c_host_err: cover property (@(posedge core_clk) disable iff (!rstn) host_err_q);
  c_fuse_set: cover property (@(posedge core_clk) disable iff (!rstn)
    vid_mode_regulator10 && fuse_sense_a);
  c_set_beats_clear: cover property (@(posedge core_clk) disable iff (!rstn)
    fault_clr && host_req.wdata[fts_pkg::FB_PAIR_1B] && diode_fault.pair_1b);
endmodule

// ---- hw/fts_sticky_reg.sv ----
// fts_sticky_reg: eight write-one-to-clear sticky flags
`timescale 1ns/1ps
module fts_sticky_reg #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // events and clear
  input wire logic [WIDTH-1:0] set_in,
  input wire logic clr_en,
  input wire logic [WIDTH-1:0] clr_mask,
  // state
  output logic [WIDTH-1:0] flags_q
);
  // ----------------------------------------
  // per-bit sticky flag, set wins over clear
  // ----------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        flags_q[i] <= 1'b0; // R16
      end else if (set_in[i]) begin
        flags_q[i] <= 1'b1;
      end else if (clr_en && clr_mask[i]) begin
        flags_q[i] <= 1'b0; // R16
      end
    end
  end
endmodule

// ---- tb/fault_and_throttle_status_tb.sv ----
// fault_and_throttle_status_tb: random and corner tests of the status bank
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module fault_and_throttle_status_tb;
  logic core_clk, rstn, fuse_sense_a, fuse_sense_b, vid_mode_regulator10;
  logic cpu1_vcore_mismatch, cpu2_vcore_mismatch, host_err_q;
  fts_pkg::fts_req_t host_req;
  fts_pkg::fts_diode_t diode_fault;
  fts_pkg::fts_duty_t cpu1_duty;
  logic [8:0] throttle_limit, dv;
  logic [7:0] host_rdata_q, fault_status_q, throttle_status_q, rd_val, exp_fault, exp_thr, m;
  int bad_count = 0;
  int samples_checked = 0;
  int corner[12] = '{0, 1, 31, 32, 63, 64, 127, 128, 191, 192, 255, 256};
  // ----------------------------------------
  // instances
  // ----------------------------------------
  fts_status_bank uut (.core_clk(core_clk), .rstn(rstn), .host_req(host_req),
    .host_rdata_q(host_rdata_q), .diode_fault(diode_fault), .fuse_sense_a(fuse_sense_a),
    .fuse_sense_b(fuse_sense_b), .vid_mode_regulator10(vid_mode_regulator10),
    .cpu1_vcore_mismatch(cpu1_vcore_mismatch), .cpu2_vcore_mismatch(cpu2_vcore_mismatch),
    .cpu1_duty(cpu1_duty), .throttle_limit(throttle_limit), .fault_status_q(fault_status_q),
    .throttle_status_q(throttle_status_q), .host_err_q(host_err_q));
  fts_host_model host (.core_clk(core_clk), .host_req(host_req), .host_rdata_q(host_rdata_q));
  // ----------------------------------------
  // expectation and checks
  // ----------------------------------------
  function automatic logic [7:0] duty_bits(input logic [8:0] d, input logic [8:0] lim);
    logic [7:0] r;
    r = 8'h00;
    r[fts_pkg::TB_ANY] = (d != 9'h000);
    if (d < fts_pkg::DUTY_12P5) r[fts_pkg::TB_LOW] = 1'b1;
    else if (d < fts_pkg::DUTY_25) r[fts_pkg::TB_SECOND] = 1'b1;
    else if (d < fts_pkg::DUTY_50) r[fts_pkg::TB_THIRD] = 1'b1;
    else if (d < fts_pkg::DUTY_75) r[fts_pkg::TB_FOURTH] = 1'b1;
    else if (d < fts_pkg::DUTY_FULL) r[fts_pkg::TB_HIGH] = 1'b1;
    else r[fts_pkg::TB_FULL] = 1'b1;
    r[fts_pkg::TB_LIMIT] = (d > lim);
    return r;
  endfunction
  task automatic check_regs();
    host.rd(fts_pkg::FAULT_ADDR, rd_val);
    `CHK(rd_val, exp_fault)
    host.rd(fts_pkg::THROT_ADDR, rd_val);
    `CHK(rd_val, exp_thr)
    `CHK(host_err_q, exp_thr[fts_pkg::TB_LIMIT])
  endtask
  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, stimulus
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #1000000;
    bad_count++;
    test_done();
  end
  initial begin
    rstn = 1'b0;
    diode_fault = '0;
    {fuse_sense_a, fuse_sense_b, vid_mode_regulator10} = 3'b000;
    {cpu1_vcore_mismatch, cpu2_vcore_mismatch} = 2'b00;
    cpu1_duty = '0;
    throttle_limit = 9'h080;
    exp_fault = 8'h00;
    exp_thr = 8'h00;
    void'($urandom(32'h5CAF));
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    check_regs();
    host.rd(8'h4D, rd_val);
    `CHK(rd_val, 8'h00)
    for (int i = 0; i < 200; i++) begin
      dv = (i < 12) ? 9'(corner[i]) : 9'($urandom_range(256));
      @(negedge core_clk);
      diode_fault <= 4'($urandom & $urandom);
      {fuse_sense_a, fuse_sense_b, vid_mode_regulator10} <= 3'($urandom);
      {cpu1_vcore_mismatch, cpu2_vcore_mismatch} <= 2'($urandom & $urandom);
      cpu1_duty <= '{valid: (i < 12) || ($urandom_range(1) == 1), duty: dv};
      throttle_limit <= 9'($urandom_range(256));
      @(negedge core_clk);
      exp_fault |= {diode_fault[3], diode_fault[2], cpu2_vcore_mismatch, cpu1_vcore_mismatch,
        fuse_sense_b & vid_mode_regulator10, fuse_sense_a & vid_mode_regulator10,
        diode_fault[1], diode_fault[0]};
      if (cpu1_duty.valid) exp_thr |= duty_bits(cpu1_duty.duty, throttle_limit);
      diode_fault <= '0;
      {fuse_sense_a, fuse_sense_b, cpu1_vcore_mismatch, cpu2_vcore_mismatch} <= 4'h0;
      cpu1_duty <= '0;
      check_regs();
      m = 8'($urandom);
      host.wr(8'h4D, m);
      host.wr(fts_pkg::FAULT_ADDR, m);
      exp_fault &= ~m;
      m = 8'($urandom);
      host.wr(fts_pkg::THROT_ADDR, m);
      exp_thr &= ~m;
    end
    // mid-run reset with flags standing
    @(negedge core_clk);
    diode_fault <= 4'hF;
    @(negedge core_clk);
    diode_fault <= '0;
    rstn <= 1'b0;
    @(negedge core_clk);
    rstn <= 1'b1;
    exp_fault = 8'h00;
    exp_thr = 8'h00;
    check_regs();
    // event and clear in the same cycle: event wins
    fork
      host.wr(fts_pkg::FAULT_ADDR, 8'hFF);
      begin
        @(negedge core_clk);
        diode_fault <= 4'h1;
        @(negedge core_clk);
        diode_fault <= '0;
      end
    join
    exp_fault = 8'h01;
    check_regs();
    test_done();
  end
endmodule

// ---- tb/fts_host_model.sv ----
// fts_host_model: management host issuing register reads and writes
`timescale 1ns/1ps
module fts_host_model (
  // clock
  input wire logic core_clk,
  // register access
  output fts_pkg::fts_req_t host_req,
  input wire logic [7:0] host_rdata_q
);
  initial host_req = '0;
  // one-cycle write pulse, ones clear flags
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    host_req <= '0;
  endtask
  // one-cycle read pulse, data taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk);
    host_req <= '0;
    d = host_rdata_q;
  endtask
endmodule
